//--- hw/pnb_pkg.sv
// Package: constants and carriers for the panel network board
package pnb_pkg;
   // Momentary line pulse: 100 ms at 100 MHz
   localparam int unsigned CLK_HZ        = 100000000;
   localparam int unsigned PULSE_MS      = 100;
   localparam int unsigned PULSE_CYCLES  = (CLK_HZ / 1000) * PULSE_MS;
   // Synchroniser depth and settle time after reset
   localparam int unsigned SYNC_STAGES   = 3;
   localparam int unsigned SETTLE_CYCLES = 4;
   localparam logic [2:0]  LINES_IDLE    = 3'h0;

   // Line bundle: alarm, silence, reset
   typedef struct packed {
      logic alarm;
      logic silence;
      logic reset;
   } pnb_lines_t;

   // Requests from the attached panel
   typedef struct packed {
      logic fire;
      logic evacuate;
      logic silence_press;
      logic master_reset;
      logic sounding;
   } pnb_panel_t;

   // Actions toward the attached panel
   typedef struct packed {
      logic net_alarm;
      logic do_silence;
      logic do_resound;
      logic do_reset;
   } pnb_act_t;
endpackage

//--- hw/pnb_line_sync.sv
// Three-stage line synchroniser with agreement filter
`timescale 1ns/10ps
module pnb_line_sync (
   input  wire logic clk_sys_in,
   input  wire logic nrst_in,
   input  wire logic line_in,
   output logic      level_out
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   logic       lvl_q;
   logic       lvl_d;

   // Stage two and three must agree; stage one only feeds stage two
   always_comb begin
      sh_d  = {sh_q[1:0], line_in};
      lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         sh_q  <= 3'h0;
         lvl_q <= 1'b0;
      end else begin
         sh_q  <= sh_d;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;
endmodule

//--- hw/pnb_net_board.sv
// Panel network board: drives and watches shared alarm, silence, reset lines
`timescale 1ns/10ps
module pnb_net_board #(
   parameter int unsigned PULSE_LEN = pnb_pkg::PULSE_CYCLES
) (
   input  wire logic               clk_sys_in,
   input  wire logic               nrst_in,
   input  wire logic               global_in,
   input  wire logic               board_count_gt1_in,
   input  wire pnb_pkg::pnb_panel_t panel_in,
   input  wire pnb_pkg::pnb_lines_t lines_in,
   output pnb_pkg::pnb_lines_t      lines_out,
   output pnb_pkg::pnb_lines_t      lines_oe_n_out,
   output logic                    zone_out,
   output logic                    config_err_out,
   output pnb_pkg::pnb_act_t        act_out
);
   typedef enum logic [0:0] {
      PNB_SETTLE = 1'b0,
      PNB_RUN    = 1'b1
   } pnb_state_t;

   localparam logic [31:0] PLEN = 32'(PULSE_LEN);

   pnb_state_t          st_q, st_d;
   logic [3:0]          settle_q, settle_d;
   logic [31:0]         sil_cnt_q, sil_cnt_d;
   logic [31:0]         rst_cnt_q, rst_cnt_d;
   logic [2:0]          lvl;
   logic [2:0]          lvl_prev_q, lvl_prev_d;
   logic [2:0]          own_q, own_d;
   logic                press_q, press_d;
   logic                mreset_q, mreset_d;
   pnb_pkg::pnb_act_t   act_q, act_d;
   logic                drv_alarm, drv_sil, drv_rst;
   logic                sil_edge, rst_edge, enabled;

   // One synchroniser per line
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         pnb_line_sync u_sync (
            .clk_sys_in (clk_sys_in),
            .nrst_in    (nrst_in),
            .line_in    (lines_in[gi]),
            .level_out  (lvl[gi])
         );
      end
   endgenerate

   // Second board on this panel disables alarm drive, zone output, pulse loads and actions
   // Inert rather than refused, so the panel still sees the error flag
   assign enabled        = !board_count_gt1_in;
   assign config_err_out = board_count_gt1_in;

   // Drive terms; low enable means driving the wire
   assign drv_alarm = enabled && (panel_in.fire || panel_in.evacuate);
   assign drv_sil   = sil_cnt_q != 32'h0;
   assign drv_rst   = rst_cnt_q != 32'h0;
   // Data is the active level; only the enables move, so peers never fight a low
   assign lines_out      = ~pnb_pkg::LINES_IDLE;
   assign lines_oe_n_out = {!drv_alarm, !drv_sil, !drv_rst};
   // Slave zone output follows local fire or evacuate
   assign zone_out       = enabled && !global_in && (panel_in.fire || panel_in.evacuate);

   // Edges of lines, only from ones not driven by us lately
   assign sil_edge = (lvl[1] != lvl_prev_q[1]) && !own_q[1];
   assign rst_edge = (lvl[0] != lvl_prev_q[0]) && !own_q[0];

   // Next state: settle, pulses, panel actions
   always_comb begin
      st_d       = st_q;
      settle_d   = settle_q;
      lvl_prev_d = lvl;
      // Own-drive mask held one sync-depth past release to hide echo
      own_d      = {drv_alarm, drv_sil || (sil_cnt_q == 32'h0 && own_q[1] && lvl[1]),
                    drv_rst || (rst_cnt_q == 32'h0 && own_q[0] && lvl[0])};
      press_d    = panel_in.silence_press;
      mreset_d   = panel_in.master_reset;
      sil_cnt_d  = drv_sil ? sil_cnt_q - 32'h1 : sil_cnt_q;
      rst_cnt_d  = drv_rst ? rst_cnt_q - 32'h1 : rst_cnt_q;
      act_d      = '0;
      case (st_q)
         PNB_SETTLE: begin
            // No events until synchronisers are filled
            if (settle_q == 4'(pnb_pkg::SETTLE_CYCLES)) begin
               st_d = PNB_RUN;
            end else begin
               settle_d = settle_q + 4'h1;
            end
         end
         PNB_RUN: begin
            if (enabled) begin
               // Status only, kept apart from fire
               act_d.net_alarm = lvl[2];
               if (panel_in.silence_press && !press_q) begin
                  sil_cnt_d = PLEN;
               end
               if (panel_in.master_reset && !mreset_q && global_in) begin
                  rst_cnt_d = PLEN;
               end
               if (sil_edge) begin
                  act_d.do_silence = panel_in.sounding;
                  act_d.do_resound = !panel_in.sounding;
               end
               if (rst_edge && !global_in && (panel_in.fire || panel_in.evacuate)
                   && !lvl[2]) begin
                  act_d.do_reset = 1'b1;
               end
            end
         end
         default: st_d = PNB_SETTLE;
      endcase
   end

   // Register everything; silence and reset lines released on reset
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         st_q       <= PNB_SETTLE;
         settle_q   <= 4'h0;
         sil_cnt_q  <= 32'h0;
         rst_cnt_q  <= 32'h0;
         lvl_prev_q <= 3'h0;
         own_q      <= 3'h0;
         press_q    <= 1'b0;
         mreset_q   <= 1'b0;
         act_q      <= '0;
      end else begin
         st_q       <= st_d;
         settle_q   <= settle_d;
         sil_cnt_q  <= sil_cnt_d;
         rst_cnt_q  <= rst_cnt_d;
         lvl_prev_q <= lvl_prev_d;
         own_q      <= own_d;
         press_q    <= press_d;
         mreset_q   <= mreset_d;
         act_q      <= act_d;
      end
   end

   assign act_out = act_q;

   // Checks: each guards one rule and sits beside the state it watches
   // Press edges in run state; the pulse must load on the next cycle
   sequence s_sil_press;
      st_q == PNB_RUN && enabled && panel_in.silence_press && !press_q;
   endsequence
   sequence s_sil_loaded;
      !lines_oe_n_out.silence && sil_cnt_q == PLEN;
   endsequence
   sequence s_rst_press;
      st_q == PNB_RUN && enabled && global_in && panel_in.master_reset && !mreset_q;
   endsequence
   sequence s_rst_loaded;
      !lines_oe_n_out.reset && rst_cnt_q == PLEN;
   endsequence

   // Line drive, zone output and status
   a_alarm_drive: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (enabled && (panel_in.fire || panel_in.evacuate)) |-> !lines_oe_n_out.alarm)
      else $error("alarm line not driven during fire");
   a_slave_no_reset: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      !global_in |=> lines_oe_n_out.reset || $past(global_in))
      else $error("slave drove reset line");
   a_zone_slave: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      global_in |-> !zone_out)
      else $error("master drove zone output");
   a_net_not_fire: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      !(panel_in.fire || panel_in.evacuate) |-> lines_oe_n_out.alarm && !zone_out)
      else $error("network alarm treated as fire");
   a_alarm_status: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q == PNB_RUN && enabled) |=> act_q.net_alarm == $past(lvl[2]))
      else $error("network alarm does not follow line");

   // Pulse start and length
   a_sil_press_pulse: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s_sil_press |=> s_sil_loaded)
      else $error("silence press gave no pulse");
   a_rst_press_pulse: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s_rst_press |=> s_rst_loaded)
      else $error("master reset gave no pulse");
   a_sil_pulse_len: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      $rose(drv_sil) |-> sil_cnt_q == PLEN)
      else $error("silence pulse length wrong");
   a_sil_pulse_ends: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (sil_cnt_q == 32'h1) |=> !drv_sil || (sil_cnt_q == PLEN))
      else $error("silence pulse did not end");
   a_rst_pulse_ends: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (rst_cnt_q == 32'h1) |=> !drv_rst || (rst_cnt_q == PLEN))
      else $error("reset pulse did not end");

   // Line events toward the panel
   a_no_early_event: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q == PNB_SETTLE) |=> act_q == '0)
      else $error("event before settle");
   a_silence_choice: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (st_q == PNB_RUN && enabled && sil_edge) |=>
      (act_q.do_silence == $past(panel_in.sounding)) && (act_q.do_resound != act_q.do_silence))
      else $error("silence choice wrong");
   a_act_one_cycle: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (act_q.do_silence || act_q.do_resound) |=> !(act_q.do_silence || act_q.do_resound))
      else $error("silence action longer than one cycle");
   a_reset_gate: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      act_q.do_reset |-> !$past(global_in) && !$past(lvl[2])
      && ($past(panel_in.fire) || $past(panel_in.evacuate)))
      else $error("slave reset without condition");
   a_second_board: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      board_count_gt1_in |-> lines_oe_n_out == 3'h7 || drv_sil || drv_rst)
      else $error("second board acted");
endmodule

//--- dv/pnb_peer_model.sv
// Peer board model: pulses the shared lines on request
`timescale 1ns/10ps
module pnb_peer_model #(
   parameter int unsigned PULSE_LEN = 8
) (
   input  wire logic           clk_sys_in,
   input  wire logic [2:0]     req_in,
   output pnb_pkg::pnb_lines_t drive_out
);
   logic [2:0] req_q  = 3'h0;
   int         cnt[3] = '{0, 0, 0};
   // Each request edge gives one momentary pulse, then the pull-down wins
   always @(posedge clk_sys_in) begin
      req_q <= req_in;
      for (int i = 0; i < 3; i++) begin
         if (req_in[i] && !req_q[i]) cnt[i] <= PULSE_LEN;
         else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
      end
   end
   // Drive only while counting
   always_comb begin
      for (int i = 0; i < 3; i++) drive_out[i] = (cnt[i] != 0);
   end
endmodule

//--- dv/test_pnb_net_board.sv
// Testbench: network board against one peer board on the lines
`timescale 1ns/10ps
module test_pnb_net_board;
   localparam int unsigned PL = 8;
   logic                clk_sys_in = 1'b0;
   logic                nrst_in    = 1'b0;
   logic                global_in  = 1'b0;
   logic                board_gt1  = 1'b0;
   logic [2:0]          peer_req   = 3'h0;
   logic                zone, cfg_err, s;
   pnb_pkg::pnb_panel_t panel      = '0;
   pnb_pkg::pnb_lines_t lines, oe_n, peer_drv, dut_do;
   pnb_pkg::pnb_act_t   act;
   int error_cnt = 0, comparisons = 0, n_sil, n_res, n_rst, n_len, n_rl;

   always #5 clk_sys_in = ~clk_sys_in;
   // Wired lines: an enabled driver puts its data on, else pull-down
   assign lines = (~oe_n & dut_do) | peer_drv;

   pnb_net_board #(.PULSE_LEN(PL)) dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .global_in(global_in), .board_count_gt1_in(board_gt1), .panel_in(panel),
      .lines_in(lines), .lines_out(dut_do), .lines_oe_n_out(oe_n), .zone_out(zone),
      .config_err_out(cfg_err), .act_out(act));
   pnb_peer_model #(.PULSE_LEN(PL)) peer (.clk_sys_in(clk_sys_in), .req_in(peer_req),
      .drive_out(peer_drv));

   // Tally action pulses and driven cycles
   always @(posedge clk_sys_in) begin
      n_sil += act.do_silence;
      n_res += act.do_resound;
      n_rst += act.do_reset;
      n_len += !oe_n.silence;
      n_rl  += !oe_n.reset;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   task automatic clr;
      {n_sil, n_res, n_rst, n_len, n_rl} = '0;
   endtask

   task automatic end_of_test;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog sized well past the expected run
   initial begin
      #50000;
      error_cnt++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'h8c8002d6));
      cyc(6);
      nrst_in = 1'b1;
      check(oe_n, 8'h07);
      check(act, 8'h00);
      cyc(10);
      // Fire, then evacuate, each drives alarm and the slave zone output
      for (int i = 0; i < 2; i++) begin
         panel = '0;
         panel[4-i] = 1'b1;
         cyc(1);
         check({zone, oe_n.alarm, lines.alarm}, 8'h05);
      end
      panel = '0;
      cyc(1);
      check(oe_n, 8'h07);
      // Foreign alarm gives a status only, no fire or panel action
      clr();
      peer_req = 3'h4;
      cyc(7);
      check({act, oe_n.alarm, zone}, 8'h22);
      peer_req = 3'h0;
      cyc(12);
      check(act, 8'h00);
      // Own silence press: one pulse of fixed length, own edges ignored
      clr();
      panel.silence_press = 1'b1;
      cyc(1);
      panel.silence_press = 1'b0;
      cyc(25);
      check(8'(n_len), 8'(PL));
      check(8'(n_sil * 16 + n_res), 8'h00);
      // Foreign silence: both edges act, by sounding state
      for (int k = 0; k < 4; k++) begin
         s = 1'($urandom % 2);
         panel.sounding = s;
         clr();
         peer_req = 3'h2;
         cyc(1);
         peer_req = 3'h0;
         cyc(22 + $urandom % 5);
         check(8'(n_sil * 16 + n_res), s ? 8'h20 : 8'h02);
      end
      // Master reset pulses the line on a master only
      for (int g = 1; g >= 0; g--) begin
         global_in = 1'(g);
         clr();
         panel.master_reset = 1'b1;
         cyc(1);
         panel.master_reset = 1'b0;
         cyc(25);
         check(8'(n_rl), g ? 8'(PL) : 8'h00);
      end
      // Slave without fire or evacuate ignores a foreign reset
      clr();
      peer_req = 3'h1;
      cyc(1);
      peer_req = 3'h0;
      cyc(25);
      check(8'(n_rst), 8'h00);
      // Reset edge seen before own fire reaches the alarm line: slave only
      for (int g = 0; g < 2; g++) begin
         global_in = 1'(g);
         clr();
         peer_req = 3'h1;
         cyc(1);
         peer_req = 3'h0;
         cyc(1);
         panel[4 - ($urandom % 2)] = 1'b1;
         cyc(20);
         check(8'(n_rst), g ? 8'h00 : 8'h01);
         panel = '0;
         cyc(10);
      end
      global_in = 1'b0;
      // Second board on the panel: flagged and inert
      board_gt1 = 1'b1;
      clr();
      panel.silence_press = 1'b1;
      cyc(1);
      check(cfg_err, 8'h01);
      panel.silence_press = 1'b0;
      cyc(20);
      check(8'(n_len), 8'h00);
      end_of_test();
   end
endmodule
